// ### core/pmx_mgmt_regs.sv
// management register bank behind the serial management interface
// assumes mdc and mdio come from outside; event inputs are on sys_clk
`timescale 1ns/1ps
`default_nettype none
module pmx_mgmt_regs (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // management serial pins
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_n,
  input wire logic [4:0] phy_addr,
  // negotiation side
  input wire logic partner_load,
  input wire logic [15:0] partner_word,
  output logic [15:0] adv_code_word,
  // receive events and state from the core
  input wire logic link_fail,
  input wire logic sync_lost,
  input wire logic bad_code,
  input wire logic start_err,
  input wire logic end_err,
  input wire logic rev_polarity,
  input wire logic babble,
  input wire logic speed_100,
  input wire logic full_duplex,
  // configuration to the core
  output logic force_link_pass,
  output logic transmitter_off,
  output logic transmitter_powerdown,
  output logic scrambler_bypass,
  output logic unscrambled_idle_reject,
  output logic receive_equalizer_on,
  output logic cable_shielded,
  output logic squelch_level_adjust,
  output logic [3:0] transmit_amplitude_field,
  output logic [1:0] edge_rate_field,
  output logic polarity_correction_off,
  output logic babble_guard_off,
  // interrupt
  output logic phy_irq
);
  logic [15:0] adv, partner, cfg1, cfg2, mask, rsvd;
  logic speed_indication, duplex_indication;
  logic [pmx_pkg::EV_W-1:0] ev_cond, ev_lat;
  logic ev_clear;
  logic [15:0] status;
  logic mdc_s1, mdc_s2, mdc_s3, mdio_s1, mdio_s2, mdc_rise;
  pmx_pkg::pmx_state_t state;
  logic [4:0] cnt;
  logic [5:0] ones;
  logic [1:0] op;
  logic [9:0] addr_sh;
  logic [15:0] sh;
  logic hit, rd_drive, rd_bit;
  logic wr_en;
  logic [4:0] wr_addr;
  logic [15:0] wr_data;
  logic [4:0] phy_addr_s1, phy_addr_s2;
  logic irq_prev, irq_pend;
  logic [3:0] pulse_cnt;

  function automatic logic [15:0] reg_read(input logic [4:0] a,
    input logic [15:0] r_adv, input logic [15:0] r_partner,
    input logic [15:0] r_cfg1, input logic [15:0] r_cfg2,
    input logic [15:0] r_status, input logic [15:0] r_mask,
    input logic [15:0] r_rsvd);
    case (a)
      pmx_pkg::ADDR_ADV: reg_read = r_adv;
      pmx_pkg::ADDR_PARTNER: reg_read = r_partner;
      pmx_pkg::ADDR_CFG1: reg_read = r_cfg1;
      pmx_pkg::ADDR_CFG2: reg_read = r_cfg2;
      pmx_pkg::ADDR_EVENT: reg_read = r_status;
      pmx_pkg::ADDR_MASK: reg_read = r_mask;
      pmx_pkg::ADDR_RSVD: reg_read = r_rsvd;
      default: reg_read = pmx_pkg::ZERO16;
    endcase
  endfunction

  function automatic logic wr_hit(input logic en, input logic [4:0] a,
    input logic [4:0] target);
    wr_hit = en && (a == target);
  endfunction

  // pin synchronisers
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mdc_s1 <= 1'b0;
      mdc_s2 <= 1'b0;
      mdc_s3 <= 1'b0;
      mdio_s1 <= 1'b1;
      mdio_s2 <= 1'b1;
      phy_addr_s1 <= 5'h00;
      phy_addr_s2 <= 5'h00;
    end
    else
    begin
      mdc_s1 <= mdc;
      mdc_s2 <= mdc_s1;
      mdc_s3 <= mdc_s2;
      mdio_s1 <= mdio_in;
      mdio_s2 <= mdio_s1;
      phy_addr_s1 <= phy_addr;
      phy_addr_s2 <= phy_addr_s1;
    end
  end
  assign mdc_rise = mdc_s2 && !mdc_s3;

  // management frame engine
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= pmx_pkg::PMX_IDLE;
      cnt <= 5'h00;
      ones <= 6'h00;
      op <= 2'h0;
      addr_sh <= 10'h000;
      sh <= 16'h0000;
      hit <= 1'b0;
      rd_drive <= 1'b0;
      rd_bit <= 1'b0;
      wr_en <= 1'b0;
      wr_addr <= 5'h00;
      wr_data <= 16'h0000;
      ev_clear <= 1'b0;
    end
    else
    begin
      wr_en <= 1'b0;
      ev_clear <= 1'b0;
      if (mdc_rise)
      begin
        case (state)
          pmx_pkg::PMX_IDLE:
            if (mdio_s2)
            begin
              if (ones != pmx_pkg::PREAMBLE_LEN)
                ones <= ones + 6'h01;
            end
            else if (ones == pmx_pkg::PREAMBLE_LEN ||
                     cfg2[pmx_pkg::CFG2_MULTI_REGISTER_ACCESS])
              state <= pmx_pkg::PMX_START;
            else
              ones <= 6'h00;
          pmx_pkg::PMX_START:
          begin
            cnt <= 5'h00;
            ones <= 6'h00;
            state <= mdio_s2 ? pmx_pkg::PMX_OP : pmx_pkg::PMX_IDLE;
          end
          pmx_pkg::PMX_OP:
          begin
            op <= {op[0], mdio_s2};
            cnt <= (cnt == pmx_pkg::CNT_OP_LAST) ? 5'h00 : cnt + 5'h01;
            if (cnt == pmx_pkg::CNT_OP_LAST)
              state <= pmx_pkg::PMX_ADDR;
          end
          pmx_pkg::PMX_ADDR:
          begin
            addr_sh <= {addr_sh[8:0], mdio_s2};
            cnt <= (cnt == pmx_pkg::CNT_ADDR_LAST) ? 5'h00 : cnt + 5'h01;
            if (cnt == pmx_pkg::CNT_ADDR_LAST)
            begin
              // frames are answered only when the frame's phy address matches phy_addr
              hit <= (addr_sh[8:4] == phy_addr_s2);
              state <= pmx_pkg::PMX_TA;
            end
          end
          pmx_pkg::PMX_TA:
          begin
            cnt <= (cnt == pmx_pkg::CNT_TA_LAST) ? 5'h00 : cnt + 5'h01;
            if (hit && op == pmx_pkg::OP_READ)
            begin
              rd_drive <= 1'b1;
              rd_bit <= 1'b0;
              if (cnt == pmx_pkg::CNT_TA_LAST)
              begin
                sh <= reg_read(addr_sh[4:0], adv, partner, cfg1, cfg2,
                  status, mask, rsvd);
                rd_bit <= 1'(reg_read(addr_sh[4:0], adv, partner, cfg1,
                  cfg2, status, mask, rsvd) >> 15);
                ev_clear <= (addr_sh[4:0] == pmx_pkg::ADDR_EVENT);
              end
            end
            if (cnt == pmx_pkg::CNT_TA_LAST)
              state <= pmx_pkg::PMX_DATA;
          end
          pmx_pkg::PMX_DATA:
          begin
            cnt <= cnt + 5'h01;
            if (rd_drive)
            begin
              rd_bit <= sh[14];
              sh <= {sh[14:0], 1'b0};
            end
            else
              sh <= {sh[14:0], mdio_s2};
            if (cnt == pmx_pkg::CNT_DATA_LAST)
            begin
              rd_drive <= 1'b0;
              cnt <= 5'h00;
              state <= pmx_pkg::PMX_IDLE;
              wr_en <= hit && (op == pmx_pkg::OP_WRITE);
              wr_addr <= addr_sh[4:0];
              wr_data <= {sh[14:0], mdio_s2};
            end
          end
          default:
            state <= pmx_pkg::PMX_IDLE;
        endcase
      end
    end
  end

  // advertisement: unsupported abilities and read-only bits stay clear
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      adv <= pmx_pkg::ADV_RST;
    else if (wr_hit(wr_en, wr_addr, pmx_pkg::ADDR_ADV))
      adv <= wr_data & pmx_pkg::ADV_WMASK;
  end
  assign adv_code_word = adv;

  // partner ability, loaded by negotiation only
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      partner <= pmx_pkg::ZERO16;
    else if (partner_load)
      partner <= partner_word;
  end

  // configuration one
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      cfg1 <= pmx_pkg::CFG1_RST;
    else if (wr_hit(wr_en, wr_addr, pmx_pkg::ADDR_CFG1))
      cfg1 <= wr_data;
  end
  assign force_link_pass = cfg1[pmx_pkg::CFG1_LNKOFF];
  assign transmitter_off = cfg1[pmx_pkg::CFG1_TXOFF];
  assign transmitter_powerdown = cfg1[pmx_pkg::CFG1_TXPDN];
  assign scrambler_bypass = cfg1[pmx_pkg::CFG1_SCRBYP];
  assign unscrambled_idle_reject = cfg1[pmx_pkg::CFG1_UNSC];
  assign receive_equalizer_on =
    !cfg1[pmx_pkg::CFG1_EQ] && speed_indication;
  assign cable_shielded = cfg1[pmx_pkg::CFG1_CABLE];
  assign squelch_level_adjust = cfg1[pmx_pkg::CFG1_SQL];
  assign transmit_amplitude_field =
    cfg1[pmx_pkg::CFG1_AMP_LSB +: 4];
  assign edge_rate_field = cfg1[pmx_pkg::CFG1_EDGE_LSB +: 2];

  // configuration two: upper bits are fixed
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      cfg2 <= pmx_pkg::CFG2_RST;
    else if (wr_hit(wr_en, wr_addr, pmx_pkg::ADDR_CFG2))
      cfg2 <= (wr_data & pmx_pkg::CFG2_WMASK) |
              (pmx_pkg::CFG2_RST & ~pmx_pkg::CFG2_WMASK);
  end
  assign polarity_correction_off = cfg2[pmx_pkg::CFG2_POLOFF];
  assign babble_guard_off = cfg2[pmx_pkg::CFG2_JABOFF];

  // mask and reserved registers
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mask <= pmx_pkg::MASK_RST;
      rsvd <= pmx_pkg::RSVD_RST;
    end
    else
    begin
      if (wr_hit(wr_en, wr_addr, pmx_pkg::ADDR_MASK))
        mask <= wr_data;
      if (wr_hit(wr_en, wr_addr, pmx_pkg::ADDR_RSVD))
        rsvd <= wr_data;
    end
  end

  // speed and duplex state
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      speed_indication <= 1'b1;
      duplex_indication <= 1'b0;
    end
    else
    begin
      speed_indication <= speed_100;
      duplex_indication <= full_duplex;
    end
  end

  // events: seven conditions plus speed and duplex changes
  assign ev_cond = {link_fail, sync_lost, bad_code, start_err, end_err,
    rev_polarity, babble, speed_100 != speed_indication,
    full_duplex != duplex_indication};

  pmx_event_latch #(
    .W(pmx_pkg::EV_W)
  ) u_events (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .cond(ev_cond),
    .clear(ev_clear),
    .latched(ev_lat)
  );

  assign status = {|ev_lat, ev_lat[pmx_pkg::EV_W-1:2], speed_indication,
    duplex_indication, 6'h00};
  assign phy_irq = |({|ev_lat, ev_lat} &
    ~mask[15:pmx_pkg::EV_LSB]);

  // interrupt pulse on the idle data line
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_prev <= 1'b0;
      irq_pend <= 1'b0;
      pulse_cnt <= 4'h0;
    end
    else
    begin
      irq_prev <= phy_irq;
      if (phy_irq && !irq_prev && cfg2[pmx_pkg::CFG2_IRQMDIO])
        irq_pend <= 1'b1;
      else if (irq_pend && pulse_cnt == 4'h0 &&
               state == pmx_pkg::PMX_IDLE)
        irq_pend <= 1'b0;
      if (pulse_cnt != 4'h0)
        pulse_cnt <= pulse_cnt - 4'h1;
      else if (irq_pend && state == pmx_pkg::PMX_IDLE)
        pulse_cnt <= 4'(pmx_pkg::IRQ_PULSE_CYC);
    end
  end

  assign mdio_oe_n = !(rd_drive || pulse_cnt != 4'h0);
  assign mdio_out = rd_drive && rd_bit;

  property p_rf_adv;
    @(posedge sys_clk) disable iff (!rst_n)
    wr_hit(wr_en, wr_addr, pmx_pkg::ADDR_ADV) |=>
      adv_code_word[pmx_pkg::ADV_RF] == $past(wr_data[pmx_pkg::ADV_RF]);
  endproperty
  a_rf_adv: assert property (p_rf_adv)
    else $error("remote fault not advertised");

  property p_no_t4;
    @(posedge sys_clk) disable iff (!rst_n)
    !adv_code_word[pmx_pkg::ADV_T4];
  endproperty
  a_no_t4: assert property (p_no_t4)
    else $error("unsupported ability advertised");

  property p_partner_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    !partner_load |=> $stable(partner);
  endproperty
  a_partner_hold: assert property (p_partner_hold)
    else $error("partner ability changed without load");

  property p_cfg1_bits;
    @(posedge sys_clk) disable iff (!rst_n)
    wr_hit(wr_en, wr_addr, pmx_pkg::ADDR_CFG1) |=>
      force_link_pass == $past(wr_data[pmx_pkg::CFG1_LNKOFF]) &&
      scrambler_bypass == $past(wr_data[pmx_pkg::CFG1_SCRBYP]) &&
      transmitter_off == $past(wr_data[pmx_pkg::CFG1_TXOFF]);
  endproperty
  a_cfg1_bits: assert property (p_cfg1_bits)
    else $error("configuration write not applied");

  property p_equalizer;
    @(posedge sys_clk) disable iff (!rst_n)
    receive_equalizer_on |-> speed_indication;
  endproperty
  a_equalizer: assert property (p_equalizer)
    else $error("equalizer on at 10M");

  property p_read_clears;
    @(posedge sys_clk) disable iff (!rst_n)
    ev_clear && ev_cond == '0 ##1 ev_cond == '0 |-> status[15] == 1'b0;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("change summary not cleared by read");

  property p_mask_blocks;
    @(posedge sys_clk) disable iff (!rst_n)
    (&mask[15:pmx_pkg::EV_LSB]) |-> !phy_irq;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks)
    else $error("masked event raised interrupt");

  property p_irq_pulse;
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(pulse_cnt != 4'h0) |-> (!mdio_oe_n && !mdio_out)[*8];
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("interrupt pulse too short");

  property p_read_turn;
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(rd_drive) |-> ##[1:40] state == pmx_pkg::PMX_DATA && rd_drive;
  endproperty
  a_read_turn: assert property (p_read_turn)
    else $error("read answer not driven");

  c_read: cover property (@(posedge sys_clk) $fell(rd_drive));
  c_write: cover property (@(posedge sys_clk) wr_en);
  c_pulse: cover property (@(posedge sys_clk) $rose(pulse_cnt != 4'h0));
  c_clear: cover property (@(posedge sys_clk) ev_clear && |ev_cond);
endmodule
`default_nettype wire

// ### core/pmx_pkg.sv
// constants, field layout and frame states of the management register bank
// assumes a 10 MHz system clock and an MDC clock sampled by that clock
`default_nettype none
package pmx_pkg;
  // register addresses on the management frame
  localparam logic [4:0] ADDR_ADV = 5'h04;
  localparam logic [4:0] ADDR_PARTNER = 5'h05;
  localparam logic [4:0] ADDR_CFG1 = 5'h10;
  localparam logic [4:0] ADDR_CFG2 = 5'h11;
  localparam logic [4:0] ADDR_EVENT = 5'h12;
  localparam logic [4:0] ADDR_MASK = 5'h13;
  localparam logic [4:0] ADDR_RSVD = 5'h14;
  // reset values and writable bits
  localparam logic [15:0] ADV_RST = 16'h01E1;
  localparam logic [15:0] ADV_WMASK = 16'hBDFF;
  localparam logic [15:0] CFG1_RST = 16'h0022;
  localparam logic [15:0] CFG2_RST = 16'hFF00;
  localparam logic [15:0] CFG2_WMASK = 16'h003F;
  localparam logic [15:0] MASK_RST = 16'hFFC0;
  localparam logic [15:0] RSVD_RST = 16'h00A0;
  localparam logic [15:0] ZERO16 = 16'h0000;
  // field positions
  localparam int ADV_RF = 13;
  localparam int ADV_T4 = 9;
  localparam int CFG1_LNKOFF = 15;
  localparam int CFG1_TXOFF = 14;
  localparam int CFG1_TXPDN = 13;
  localparam int CFG1_SCRBYP = 10;
  localparam int CFG1_UNSC = 9;
  localparam int CFG1_EQ = 8;
  localparam int CFG1_CABLE = 7;
  localparam int CFG1_SQL = 6;
  localparam int CFG1_AMP_LSB = 2;
  localparam int CFG1_EDGE_LSB = 0;
  localparam int CFG2_POLOFF = 5;
  localparam int CFG2_JABOFF = 4;
  localparam int CFG2_MULTI_REGISTER_ACCESS = 3;
  localparam int CFG2_IRQMDIO = 2;
  localparam int EV_W = 9;
  localparam int EV_LSB = 6;
  // edge rate codes
  localparam logic [1:0] EDGE_MINUS_QTR = 2'h3;
  localparam logic [1:0] EDGE_NOMINAL = 2'h2;
  localparam logic [1:0] EDGE_PLUS_QTR = 2'h1;
  localparam logic [1:0] EDGE_PLUS_HALF = 2'h0;
  // management frame
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [4:0] CNT_OP_LAST = 5'h01;
  localparam logic [4:0] CNT_ADDR_LAST = 5'h09;
  localparam logic [4:0] CNT_TA_LAST = 5'h01;
  localparam logic [4:0] CNT_DATA_LAST = 5'h0F;
  // interrupt pulse on the data line
  localparam int CLK_PERIOD_NS = 100;
  localparam int IRQ_PULSE_NS = 800;
  localparam int IRQ_PULSE_CYC =
    (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    PMX_IDLE = 3'b000,
    PMX_START = 3'b001,
    PMX_OP = 3'b010,
    PMX_ADDR = 3'b011,
    PMX_TA = 3'b100,
    PMX_DATA = 3'b101
  } pmx_state_t;
endpackage
`default_nettype wire

// ### core/pmx_event_latch.sv
// sticky event bits, cleared by a read strobe unless still present
// assumes conditions and clear come from the system clock domain
`timescale 1ns/1ps
`default_nettype none
module pmx_event_latch #(
  parameter int W = 9
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // events
  input wire logic [W-1:0] cond,
  input wire logic clear,
  output logic [W-1:0] latched
);
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      // a new event wins over the read clear
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
          latched[i] <= 1'b0;
        else if (cond[i])
          latched[i] <= 1'b1;
        else if (clear)
          latched[i] <= 1'b0;
      end
    end
  endgenerate

  property p_set_wins;
    @(posedge sys_clk) disable iff (!rst_n)
    (|cond) |=> ((latched & $past(cond)) == $past(cond));
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost while clearing");
endmodule
`default_nettype wire

// ### tb/pmx_mgmt_station.sv
// mac-side management station driving whole frames on mdc and mdio
// assumes the bench resolves the mdio wire with a pull-up
`timescale 1ns/1ps
`default_nettype none
module pmx_mgmt_station (
  // clock
  input wire logic sys_clk,
  // management pins
  input wire logic mdio_wire,
  output logic mdc,
  output logic mdio_drv,
  output logic mdio_drv_en
);
  logic ta_seen;
  initial
  begin
    mdc = 1'b0;
    mdio_drv = 1'b0;
    mdio_drv_en = 1'b0;
    ta_seen = 1'b1;
  end
  // one bit: low half, sample, rise, high half
  task automatic xbit(input logic d, input logic en, output logic s);
    mdio_drv = d;
    mdio_drv_en = en;
    mdc = 1'b0;
    repeat (4) @(negedge sys_clk);
    s = mdio_wire;
    mdc = 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask
  // whole frame with preamble; clock stands still afterwards
  task automatic frame(input logic [1:0] op, input logic [4:0] pa,
    input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
    logic s;
    logic rdop;
    logic [13:0] h;
    h = {2'b01, op, pa, ra};
    rdop = (op == pmx_pkg::OP_READ);
    rd = 16'h0000;
    for (int i = 0; i < 32; i++)
      xbit(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--)
      xbit(h[i], 1'b1, s);
    xbit(1'b1, !rdop, s);
    xbit(1'b0, !rdop, ta_seen);
    for (int i = 15; i >= 0; i--)
    begin
      xbit(wd[i], !rdop, s);
      rd[i] = s;
    end
    mdio_drv_en = 1'b0;
    mdc = 1'b0;
    repeat (8) @(negedge sys_clk);
  endtask
endmodule
`default_nettype wire

// ### tb/tb_pmx_mgmt_regs.sv
// bench for the management register bank
// assumes a station model on mdc/mdio and a pulled-up data wire
`timescale 1ns/1ps
`default_nettype none
module tb_pmx_mgmt_regs;
  typedef struct packed {logic [4:0] a; logic w; logic [15:0] d;} pmx_row_t;
  logic sys_clk, rst_n, mdc, mdio_in, mdio_out, mdio_oe_n, drv, drv_en;
  logic partner_load, speed_100, full_duplex, phy_irq, drove;
  logic [15:0] partner_word, adv_code_word, rd;
  logic [6:0] ev;
  logic flp, txo, txp, scb, uir, eqo, cbs, sqa, pco, bgo;
  logic [3:0] amp;
  logic [1:0] edge_rate;
  int failures, checks_done, lowc;
  pmx_row_t rows [0:16] = '{
    '{pmx_pkg::ADDR_ADV, 1'b0, 16'h01E1}, '{pmx_pkg::ADDR_PARTNER, 1'b0, 16'h0000},
    '{pmx_pkg::ADDR_CFG1, 1'b0, 16'h0022}, '{pmx_pkg::ADDR_CFG2, 1'b0, 16'hFF00},
    '{pmx_pkg::ADDR_EVENT, 1'b0, 16'h0080}, '{pmx_pkg::ADDR_MASK, 1'b0, 16'hFFC0},
    '{pmx_pkg::ADDR_RSVD, 1'b0, 16'h00A0}, '{pmx_pkg::ADDR_ADV, 1'b1, 16'hFFFF},
    '{pmx_pkg::ADDR_ADV, 1'b0, 16'hBDFF}, '{pmx_pkg::ADDR_PARTNER, 1'b1, 16'hFFFF},
    '{pmx_pkg::ADDR_PARTNER, 1'b0, 16'h0000}, '{pmx_pkg::ADDR_CFG1, 1'b1, 16'hFFFF},
    '{pmx_pkg::ADDR_CFG1, 1'b0, 16'hFFFF}, '{pmx_pkg::ADDR_CFG2, 1'b1, 16'h0033},
    '{pmx_pkg::ADDR_CFG2, 1'b0, 16'hFF33}, '{5'h07, 1'b1, 16'h1234},
    '{5'h07, 1'b0, 16'h0000}};
  assign mdio_in = !mdio_oe_n ? mdio_out : (drv_en ? drv : 1'b1);
  pmx_mgmt_station u_sta (.sys_clk(sys_clk), .mdio_wire(mdio_in),
    .mdc(mdc), .mdio_drv(drv), .mdio_drv_en(drv_en));
  pmx_mgmt_regs dut (.sys_clk(sys_clk), .rst_n(rst_n), .mdc(mdc),
    .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
    .phy_addr(5'h01), .partner_load(partner_load),
    .partner_word(partner_word), .adv_code_word(adv_code_word),
    .link_fail(ev[6]), .sync_lost(ev[5]), .bad_code(ev[4]),
    .start_err(ev[3]), .end_err(ev[2]), .rev_polarity(ev[1]),
    .babble(ev[0]), .speed_100(speed_100), .full_duplex(full_duplex),
    .force_link_pass(flp), .transmitter_off(txo),
    .transmitter_powerdown(txp), .scrambler_bypass(scb),
    .unscrambled_idle_reject(uir), .receive_equalizer_on(eqo),
    .cable_shielded(cbs), .squelch_level_adjust(sqa),
    .transmit_amplitude_field(amp), .edge_rate_field(edge_rate),
    .polarity_correction_off(pco), .babble_guard_off(bgo),
    .phy_irq(phy_irq));
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk)
    if (mdio_oe_n === 1'b0)
      drove = 1'b1;
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] x;
    u_sta.frame(pmx_pkg::OP_WRITE, 5'h01, a, d, x);
  endtask
  task automatic rdr(input logic [4:0] a, input logic [15:0] e);
    u_sta.frame(pmx_pkg::OP_READ, 5'h01, a, 16'h0000, rd);
    chk("turnaround", 16'(u_sta.ta_seen), 16'h0000);
    chk($sformatf("reg %h", a), rd, e);
  endtask
  task automatic pulse(input int i, input logic [15:0] e);
    @(negedge sys_clk) ev[i] = 1'b1;
    @(negedge sys_clk) ev[i] = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("irq", 16'(phy_irq), e);
  endtask
  function automatic logic [15:0] outs();
    return {flp, txo, txp, scb, uir, eqo, cbs, sqa, amp, edge_rate, pco, bgo};
  endfunction
  initial
  begin
    #6000000;
    failures++;
    end_of_test();
  end
  initial
  begin
    {rst_n, partner_load, partner_word, ev, full_duplex} = '0;
    speed_100 = 1'b1;
    drove = 1'b0;
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    foreach (rows[i])
      if (rows[i].w)
        wr(rows[i].a, rows[i].d);
      else
        rdr(rows[i].a, rows[i].d);
    chk("cfg outs", outs(), 16'hFBFF);
    chk("adv word", adv_code_word, 16'hBDFF);
    for (int k = 0; k < 4; k++)
    begin
      wr(pmx_pkg::ADDR_CFG1, 16'(k));
      chk("edge outs", outs(), {8'h04, 4'h0, 2'(k), 2'b11});
    end
    @(negedge sys_clk) {partner_load, partner_word} = {1'b1, 16'h4DE1};
    @(negedge sys_clk) partner_load = 1'b0;
    rdr(pmx_pkg::ADDR_PARTNER, 16'h4DE1);
    pulse(6, 16'h0000);
    rdr(pmx_pkg::ADDR_EVENT, 16'hC080);
    rdr(pmx_pkg::ADDR_EVENT, 16'h0080);
    wr(pmx_pkg::ADDR_MASK, 16'h0000);
    for (int i = 0; i < 7; i++)
    begin
      pulse(i, 16'h0001);
      rdr(pmx_pkg::ADDR_EVENT, 16'h8080 | (16'h0100 << i));
      rdr(pmx_pkg::ADDR_EVENT, 16'h0080);
      chk("irq clear", 16'(phy_irq), 16'h0000);
    end
    @(negedge sys_clk) ev[0] = 1'b1;
    rdr(pmx_pkg::ADDR_EVENT, 16'h8180);
    ev[0] = 1'b0;
    rdr(pmx_pkg::ADDR_EVENT, 16'h8180);
    rdr(pmx_pkg::ADDR_EVENT, 16'h0080);
    wr(pmx_pkg::ADDR_CFG2, 16'h0004);
    lowc = 0;
    @(negedge sys_clk) ev[2] = 1'b1;
    @(negedge sys_clk) ev[2] = 1'b0;
    repeat (40)
    begin
      @(negedge sys_clk);
      if (mdio_oe_n === 1'b0 && mdio_out === 1'b0)
        lowc++;
    end
    chk("irq pulse", 16'(lowc), 16'(pmx_pkg::IRQ_PULSE_CYC));
    rdr(pmx_pkg::ADDR_EVENT, 16'h8480);
    {speed_100, full_duplex} = 2'b01;
    // let the interrupt pulse on the data line finish before the preamble
    repeat (20) @(negedge sys_clk);
    rdr(pmx_pkg::ADDR_EVENT, 16'h8040);
    rdr(pmx_pkg::ADDR_EVENT, 16'h0040);
    drove = 1'b0;
    u_sta.frame(pmx_pkg::OP_READ, 5'h02, pmx_pkg::ADDR_CFG2, 16'h0000, rd);
    chk("other phy", {rd[15:1], drove}, 16'hFFFE);
    @(negedge sys_clk) rst_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    rdr(pmx_pkg::ADDR_CFG1, 16'h0022);
    rdr(pmx_pkg::ADDR_MASK, 16'hFFC0);
    rdr(pmx_pkg::ADDR_RSVD, 16'h00A0);
    end_of_test();
  end
endmodule
`default_nettype wire
